// ---- src/rdms_regs.svh ----
`ifndef RDMS_REGS_SVH
`define RDMS_REGS_SVH

// Master clock period in ps (40 MHz)
`define RDMS_CLK_PERIOD_PS 25000
// Cycles from reset pin rise to first fetch
`define RDMS_FETCH_DELAY_CYC 80
// Sampling window before reset release, in master clock cycles
`define RDMS_SAMPLE_WIN_CYC 10
// Fetch address after any reset
`define RDMS_RESET_VECTOR 32'h0000_0000
// Reset values of latched modes
`define RDMS_BOOT_SEL_RST 1'b1
`define RDMS_FLOAT_RST 1'b0
// Width of fetch delay counter
`define RDMS_FETCH_CNT_W 7
// Width of the sampling window counter
`define RDMS_WIN_CNT_W 4

`endif

// ---- src/rdms_pkg.sv ----
package rdms_pkg;

	typedef enum logic [1:0] {
		RDMS_ST_RESET,
		RDMS_ST_DELAY,
		RDMS_ST_RUN
	} rdms_state_e;

	typedef struct packed {
		logic boot_ext16;
		logic float_mode;
	} rdms_mode_s;

	typedef struct packed {
		logic io_out;
		logic io_oe;
		logic pio_sel;
	} rdms_pad_s;

endpackage : rdms_pkg

// ---- src/rdms_sync.sv ----
`timescale 1ns/10ps
`include "rdms_regs.svh"

// Two-flop synchroniser with a preset value applied while i_set is high
module rdms_sync (
	input wire logic i_clk,
	input wire logic i_set,
	input wire logic i_d,
	output logic o_q
);
	logic meta_r;

	always_ff @(posedge i_clk or posedge i_set) begin
		if (i_set) begin
			meta_r <= 1'b0;
			o_q <= 1'b0;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule : rdms_sync

// ---- src/rdms_sampler.sv ----
`timescale 1ns/10ps
`include "rdms_regs.svh"

// Tracks whether a synchronised level stayed low over the last window cycles
module rdms_sampler (
	input wire logic i_clk,
	input wire logic i_clr,
	input wire logic i_level,
	output logic o_low_run
);
	logic [`RDMS_WIN_CNT_W-1:0] cnt_r;

	always_ff @(posedge i_clk) begin
		if (i_clr || i_level) begin
			cnt_r <= '0;
		end else if (cnt_r != `RDMS_WIN_CNT_W'(`RDMS_SAMPLE_WIN_CYC)) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign o_low_run = (cnt_r == `RDMS_WIN_CNT_W'(`RDMS_SAMPLE_WIN_CYC));
endmodule : rdms_sampler

// ---- src/rdms_top.sv ----
// Summary of operation
// - Reset is entered on the second clock edge after the reset pin falls and left only on a clock edge.
// - The first processor fetch is issued exactly eighty clocks after the reset pin rises.
// - Every reset returns peripheral registers to defaults and the fetch address to zero.
// - The clock output is low during external reset and afterwards toggles on every clock edge, at half the clock rate.
// - The clock output pad becomes a plain I/O line only when the I/O controller selects it.
// - A configured watchdog reset acts like the external reset pin.
// - A watchdog reset neither samples nor changes the boot and float modes.
// - The external reset pin takes priority over a simultaneous watchdog reset.
// - Float mode is entered if the float select pin is low the last ten clocks before release.
// - In float mode every output driver of the device is disabled.
// - The float select pad is shared with I/O line 21 and serial transmit, sampled in reset.
// - After reset all peripheral I/O pins are inputs; the pads are forced to inputs during reset and in float mode, otherwise pass i_periph_oe.
// - Boot memory is chosen from the boot select level of the last ten clocks before release.
// - A boot select level of zero boots from sixteen-bit external memory on chip select zero.
`timescale 1ns/10ps
`include "rdms_regs.svh"

module rdms_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ext_reset_n_pin,
	input wire logic i_wdog_reset_en,
	input wire logic i_wdog_reset_req,
	input wire logic i_float_select_n_pin,
	input wire logic i_boot_select_pin,
	input wire rdms_pkg::rdms_pad_s i_clk_out_pad,
	input wire rdms_pkg::rdms_pad_s i_io_line_21_pad,
	input wire logic i_serial1_tx_out,
	input wire logic i_serial1_tx_sel,
	input wire logic [31:0] i_periph_oe,
	output logic o_main_clk_out_pin,
	output logic o_main_clk_out_oe,
	output logic o_io_line_21_out,
	output logic o_io_line_21_oe,
	output logic [31:0] o_periph_oe,
	output logic o_core_reset,
	output logic o_periph_reset,
	output logic o_fetch_start,
	output logic [31:0] o_fetch_addr,
	output rdms_pkg::rdms_mode_s o_mode
);
	import rdms_pkg::*;

	logic rst_sync;
	logic float_sync;
	logic boot_sync;
	logic ext_rst_r;
	logic wdog_rst_r;
	logic float_low_run;
	logic boot_low_run;
	logic clk_gate_r;
	logic [`RDMS_FETCH_CNT_W-1:0] fetch_cnt_r;
	rdms_state_e state_r;
	rdms_mode_s mode_r;
	logic reset_any;

	// Release is synchronised; assertion is asynchronous through the preset
	rdms_sync u_rst_sync (
		.i_clk(i_clk),
		.i_set(~i_ext_reset_n_pin),
		.i_d(1'b1),
		.o_q(rst_sync)
	);

	// Pad levels are sampled through synchronisers while reset is held
	rdms_sync u_float_sync (
		.i_clk(i_clk),
		.i_set(i_rst),
		.i_d(~i_float_select_n_pin),
		.o_q(float_sync)
	);

	rdms_sync u_boot_sync (
		.i_clk(i_clk),
		.i_set(i_rst),
		.i_d(~i_boot_select_pin),
		.o_q(boot_sync)
	);

	// Counts cycles in which each pin has been low, cleared while the pin is high or out of ext reset
	rdms_sampler u_float_win (
		.i_clk(i_clk),
		.i_clr(rst_sync),
		.i_level(~float_sync),
		.o_low_run(float_low_run)
	);

	rdms_sampler u_boot_win (
		.i_clk(i_clk),
		.i_clr(rst_sync),
		.i_level(~boot_sync),
		.o_low_run(boot_low_run)
	);

	always_comb begin
		reset_any = ext_rst_r | wdog_rst_r;
	end

	// External reset first, watchdog only when enabled and pin is released
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_rst_r <= 1'b1;
			wdog_rst_r <= 1'b0;
		end else begin
			ext_rst_r <= ~rst_sync;
			wdog_rst_r <= rst_sync & i_wdog_reset_en & i_wdog_reset_req;
		end
	end

	// Modes latched only on the release of the external pin
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_r.boot_ext16 <= ~`RDMS_BOOT_SEL_RST;
			mode_r.float_mode <= `RDMS_FLOAT_RST;
		end else if (ext_rst_r && rst_sync) begin
			mode_r.float_mode <= float_low_run;
			// Low boot select picks 16-bit external memory on chip select 0
			mode_r.boot_ext16 <= boot_low_run;
		end
	end

	// Fetch delay sequencing
	always_ff @(posedge i_clk) begin
		if (i_rst || reset_any) begin
			state_r <= RDMS_ST_RESET;
			fetch_cnt_r <= '0;
		end else begin
			unique case (state_r)
				RDMS_ST_RESET: begin
					state_r <= RDMS_ST_DELAY;
					// Two synchroniser and two sequencing edges have passed since the pin rose
					fetch_cnt_r <= `RDMS_FETCH_CNT_W'(4);
				end
				RDMS_ST_DELAY: begin
					if (fetch_cnt_r == `RDMS_FETCH_CNT_W'(`RDMS_FETCH_DELAY_CYC - 1)) begin
						state_r <= RDMS_ST_RUN;
					end
					fetch_cnt_r <= fetch_cnt_r + 1'b1;
				end
				RDMS_ST_RUN: begin
					state_r <= RDMS_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || reset_any) begin
			o_core_reset <= 1'b1;
			o_periph_reset <= 1'b1;
			o_fetch_start <= 1'b0;
			o_fetch_addr <= `RDMS_RESET_VECTOR;
		end else begin
			o_core_reset <= (state_r != RDMS_ST_RUN) &&
				!(state_r == RDMS_ST_DELAY &&
				fetch_cnt_r == `RDMS_FETCH_CNT_W'(`RDMS_FETCH_DELAY_CYC - 1));
			o_periph_reset <= 1'b0;
			o_fetch_start <= (state_r == RDMS_ST_DELAY) &&
				(fetch_cnt_r == `RDMS_FETCH_CNT_W'(`RDMS_FETCH_DELAY_CYC - 1));
			o_fetch_addr <= `RDMS_RESET_VECTOR;
		end
	end

	// Clock copy is gated low in external reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			clk_gate_r <= 1'b0;
		end else begin
			clk_gate_r <= rst_sync & ~ext_rst_r;
		end
	end

	// Pad muxing and driver disable
	always_ff @(posedge i_clk) begin
		if (i_rst || reset_any) begin
			o_main_clk_out_oe <= 1'b0;
			o_io_line_21_out <= 1'b0;
			o_io_line_21_oe <= 1'b0;
			o_periph_oe <= '0;
		end else begin
			o_main_clk_out_oe <= ~mode_r.float_mode &
				(i_clk_out_pad.pio_sel ? i_clk_out_pad.io_oe : 1'b1);
			o_io_line_21_out <= i_serial1_tx_sel ? i_serial1_tx_out : i_io_line_21_pad.io_out;
			o_io_line_21_oe <= ~mode_r.float_mode &
				(i_serial1_tx_sel | i_io_line_21_pad.io_oe);
			o_periph_oe <= mode_r.float_mode ? '0 : i_periph_oe;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_main_clk_out_pin <= 1'b0;
		end else if (i_clk_out_pad.pio_sel && !reset_any) begin
			o_main_clk_out_pin <= i_clk_out_pad.io_out;
		end else begin
			o_main_clk_out_pin <= clk_gate_r & ~o_main_clk_out_pin;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_mode <= '0;
		end else begin
			o_mode <= mode_r;
		end
	end

	fetch_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(rst_sync) |-> ##78 o_fetch_start)
		else $error("fetch not 80 cycles after release");
	clk_low_rst_a: assert property (@(posedge i_clk) disable iff (i_rst)
		ext_rst_r && !i_clk_out_pad.pio_sel |=> !o_main_clk_out_pin)
		else $error("clock out not low in reset");
	float_drv_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
		mode_r.float_mode |=> o_periph_oe == '0 && !o_io_line_21_oe)
		else $error("driver on in float mode");
	wdog_mode_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		wdog_rst_r |=> $stable(mode_r))
		else $error("mode changed by watchdog");
	wdog_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
		wdog_rst_r |=> o_core_reset && o_periph_reset)
		else $error("watchdog reset ignored");
	ext_prio_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!rst_sync |=> !wdog_rst_r)
		else $error("watchdog over external reset");
	fetch_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fetch_start |-> o_fetch_addr == `RDMS_RESET_VECTOR)
		else $error("fetch address not zero");
	io_input_a: assert property (@(posedge i_clk) disable iff (i_rst)
		reset_any |=> o_periph_oe == '0)
		else $error("io driven in reset");
	pio_clk_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!ext_rst_r && !reset_any && i_clk_out_pad.pio_sel |=>
		o_main_clk_out_pin == $past(i_clk_out_pad.io_out))
		else $error("clock pad not io");
	float_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
		ext_rst_r && rst_sync |=> mode_r.float_mode == $past(float_low_run))
		else $error("float mode not latched");

	// Cycles since the design last left any reset, to pin the fetch to the release
	logic [`RDMS_FETCH_CNT_W:0] rel_cnt_r;

	always_ff @(posedge i_clk) begin
		if (i_rst || !rst_sync || reset_any) begin
			rel_cnt_r <= '0;
		end else if (rel_cnt_r != '1) begin
			rel_cnt_r <= rel_cnt_r + 1'b1;
		end
	end

	// Reset entry and fetch timing
	rst_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!rst_sync |-> ##2 (o_core_reset && o_periph_reset))
		else $error("reset pin did not reset");
	fetch_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fetch_start |-> rel_cnt_r == (`RDMS_FETCH_CNT_W + 1)'(`RDMS_FETCH_DELAY_CYC - 3))
		else $error("fetch at wrong distance from release");
	fetch_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fetch_start |=> !o_fetch_start)
		else $error("fetch pulse too long");
	per_rst_rel_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fetch_start |-> !o_periph_reset && !o_core_reset)
		else $error("fetch while still in reset");
	fetch_addr_rst_a: assert property (@(posedge i_clk) disable iff (i_rst)
		reset_any |=> o_fetch_addr == `RDMS_RESET_VECTOR && !o_fetch_start)
		else $error("fetch state not cleared by reset");

	// Clock output and pad drivers
	clk_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
		clk_gate_r && !i_clk_out_pad.pio_sel |=>
		o_main_clk_out_pin != $past(o_main_clk_out_pin))
		else $error("clock out not running");
	clk_oe_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!reset_any && !mode_r.float_mode && !i_clk_out_pad.pio_sel |=> o_main_clk_out_oe)
		else $error("clock pad not driven");
	clk_oe_float_a: assert property (@(posedge i_clk) disable iff (i_rst)
		mode_r.float_mode |=> !o_main_clk_out_oe)
		else $error("clock pad driven in float mode");
	pad_in_rst_a: assert property (@(posedge i_clk) disable iff (i_rst)
		reset_any |=> !o_main_clk_out_oe && !o_io_line_21_oe)
		else $error("pad driven in reset");
	periph_oe_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!reset_any && !mode_r.float_mode |=> o_periph_oe == $past(i_periph_oe))
		else $error("peripheral enables not passed");
	l21_tx_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!mode_r.float_mode && !reset_any && i_serial1_tx_sel |=>
		o_io_line_21_out == $past(i_serial1_tx_out) && o_io_line_21_oe)
		else $error("line 21 not serial transmit");

	// Watchdog and latched modes
	wdog_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
		wdog_rst_r |-> $past(i_wdog_reset_en && i_wdog_reset_req))
		else $error("watchdog reset without request");
	mode_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!(ext_rst_r && rst_sync) |=> $stable(mode_r))
		else $error("mode changed outside release");
	boot_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
		ext_rst_r && rst_sync |=> mode_r.boot_ext16 == $past(boot_low_run))
		else $error("boot mode not latched");
	mode_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
		1'b1 |=> o_mode == $past(mode_r))
		else $error("mode output stale");

	fetch_cov_c: cover property (@(posedge i_clk) o_fetch_start);
	float_cov_c: cover property (@(posedge i_clk) mode_r.float_mode);
	wdog_cov_c: cover property (@(posedge i_clk) wdog_rst_r);
	boot16_cov_c: cover property (@(posedge i_clk) mode_r.boot_ext16);
	prio_cov_c: cover property (@(posedge i_clk) !rst_sync && i_wdog_reset_en && i_wdog_reset_req);
endmodule : rdms_top

// ---- tb/rdms_board.sv ----
`timescale 1ns/10ps

// Board reset circuit: holds the reset pin low for a set length and drives the strap levels
module rdms_board (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_len,
	input wire logic i_float_lo,
	input wire logic i_boot_lo,
	output logic o_rst_n,
	output logic o_float_n,
	output logic o_boot
);
	logic [7:0] cnt_r = 8'hff;
	// Clock keeps running through the hold, which never lasts under ten cycles
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			cnt_r <= (i_len < 8'h0c) ? 8'h0c : i_len;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
	assign o_rst_n = (cnt_r == 8'h00);
	// Strap levels stand for the whole hold; float strap high unless float mode is wanted
	assign o_float_n = !i_float_lo;
	assign o_boot = !i_boot_lo;
endmodule : rdms_board

// ---- tb/rdms_top_bench.sv ----
`timescale 1ns/10ps
`include "rdms_regs.svh"

module rdms_top_bench;
	import rdms_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic go = 1'b1, float_lo = 1'b0, boot_lo = 1'b0, rst_n, float_n, boot;
	logic wd_en = 1'b0, wd_req = 1'b0, tx_sel = 1'b0;
	logic [31:0] p_oe = 32'h0;
	rdms_pad_s ck_pad = 3'h0, l21_pad = 3'h0;
	logic ck_o, ck_oe, l21_o, l21_oe, core_rst, per_rst, fetch;
	logic [31:0] per_oe, f_addr;
	rdms_mode_s mode;
	int n_fail = 0, checks = 0, cyc = 0, n;

	initial forever #12.5 i_clk = ~i_clk;

	rdms_board board (.i_clk(i_clk), .i_go(go), .i_len(8'h0c), .i_float_lo(float_lo),
		.i_boot_lo(boot_lo), .o_rst_n(rst_n), .o_float_n(float_n), .o_boot(boot));

	rdms_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ext_reset_n_pin(rst_n), .i_wdog_reset_en(wd_en),
		.i_wdog_reset_req(wd_req), .i_float_select_n_pin(float_n), .i_boot_select_pin(boot),
		.i_clk_out_pad(ck_pad), .i_io_line_21_pad(l21_pad), .i_serial1_tx_out(1'b1),
		.i_serial1_tx_sel(tx_sel), .i_periph_oe(p_oe), .o_main_clk_out_pin(ck_o),
		.o_main_clk_out_oe(ck_oe), .o_io_line_21_out(l21_o), .o_io_line_21_oe(l21_oe),
		.o_periph_oe(per_oe), .o_core_reset(core_rst), .o_periph_reset(per_rst),
		.o_fetch_start(fetch), .o_fetch_addr(f_addr), .o_mode(mode));

	task automatic end_sim;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp=%h seen=%h", what, exp, seen);
		end
	endtask : chk

	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask : tick

	// Pulse the board reset, then count edges from pin release to the first fetch
	task automatic pin_reset(input logic f, input logic b);
		@(posedge i_clk);
		float_lo <= f;
		boot_lo <= b;
		go <= 1'b1;
		tick();
		go <= 1'b0;
		repeat (6) tick();
		wd_req <= 1'b0;
		chk("clk_out_rst", ck_o, 0);
		chk("core_rst_in", core_rst, 1);
		chk("per_rst_in", per_rst, 1);
		while (rst_n !== 1'b1) tick();
		n = 0;
		while (fetch !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		chk("fetch_cyc", n, `RDMS_FETCH_DELAY_CYC);
		chk("fetch_addr", f_addr, `RDMS_RESET_VECTOR);
	endtask : pin_reset

	task automatic t_normal;
		pin_reset(1'b0, 1'b0);
		chk("mode", mode, 2'b00);
		chk("core_rst", core_rst, 0);
		chk("per_rst", per_rst, 0);
		chk("per_oe", per_oe, 0);
		chk("ck_oe", ck_oe, 1);
		n = ck_o;
		tick();
		chk("ck_toggle", ck_o, !n[0]);
		$display("test normal done");
	endtask : t_normal

	task automatic t_float;
		p_oe <= 32'hffff_ffff;
		pin_reset(1'b1, 1'b0);
		chk("float", mode.float_mode, 1);
		chk("per_oe_f", per_oe, 0);
		chk("ck_oe_f", ck_oe, 0);
		chk("l21_oe_f", l21_oe, 0);
		$display("test float done");
	endtask : t_float

	task automatic t_boot;
		pin_reset(1'b0, 1'b1);
		chk("boot16", mode, 2'b10);
		chk("per_oe_b", per_oe, 32'hffff_ffff);
		$display("test boot done");
	endtask : t_boot

	task automatic t_wdog;
		float_lo <= 1'b1;
		boot_lo <= 1'b0;
		wd_en <= 1'b1;
		wd_req <= 1'b1;
		tick();
		wd_req <= 1'b0;
		repeat (3) tick();
		chk("wd_core_rst", core_rst, 1);
		n = 0;
		while (fetch !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		chk("wd_fetch", fetch, 1);
		chk("wd_mode", mode, 2'b10);
		$display("test wdog done");
	endtask : t_wdog

	task automatic t_prio;
		wd_req <= 1'b1;
		pin_reset(1'b0, 1'b0);
		wd_req <= 1'b0;
		chk("prio_mode", mode, 2'b00);
		$display("test prio done");
	endtask : t_prio

	task automatic t_pio;
		ck_pad <= 3'h7;
		l21_pad <= 3'h7;
		repeat (4) tick();
		chk("pio_ck", {ck_o, ck_oe}, 2'b11);
		tick();
		chk("pio_ck2", ck_o, 1);
		chk("pio_l21", {l21_o, l21_oe}, 2'b11);
		$display("test pio done");
	endtask : t_pio

	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		go <= 1'b0;
		t_normal();
		t_float();
		t_boot();
		t_wdog();
		t_prio();
		t_pio();
		end_sim();
	end
endmodule : rdms_top_bench
